// file: pmgc_pkg.sv
// What this block does
// - Each output pin drives only when enabled, or for pins 2/4 when rerouted
// - Enabled pin level follows its level bit unless its alternate signal is routed
// - Second pin can carry the data-ready interrupt
// - Fourth pin can flag standby mode
// - Each channel's switch bit steers bridge switch while converting; switch is off in other modes
// - Setup gain field selects one of eight gains
// - Gain bypass forces unity gain
// - Bias field selects pins tied to mid-supply
// - Supply reset restores all registers to defaults
// - Analog supply dips never reset the device
// - Power-on flag set by reset, cleared on read
// - Channel 0 defaults enabled, inputs 0/1, setup 0
// - Setup 0 defaults unity gain, sinc3, rate 0x30
// - Converter control defaults continuous, offset binary
// - Only early access error detection enabled
// - Mode codes 2/3/4 are standby, power-down, idle
// - Power-down only from standby, else continuous
// - Power-down drops everything and loses registers
// - Idle holds modulator and filter in reset
// - Idle ends on a new mode write
// - Standby keeps registers, conv_pending_n held high
// - Standby ends on a new mode write
// - Sixty-four ones on serial input reset everything
package pmgc_pkg;

    localparam int ADDR_W = 6;
    localparam int N_CHAN = 16;
    localparam int N_SETUP = 8;

    // Register map
    localparam logic [5:0] STATUS_ADDR = 6'h00;
    localparam logic [5:0] CTRL_ADDR = 6'h01;
    localparam logic [5:0] IO_ADDR = 6'h03;
    localparam logic [5:0] BIAS_ADDR = 6'h04;
    localparam logic [5:0] MISC_ADDR = 6'h05;
    localparam logic [5:0] ERREN_ADDR = 6'h07;
    localparam logic [5:0] CHAN_BASE = 6'h09;
    localparam logic [5:0] CHAN_LAST = 6'h18;
    localparam logic [5:0] CFG_BASE = 6'h19;
    localparam logic [5:0] CFG_LAST = 6'h20;
    localparam logic [5:0] FILT_BASE = 6'h21;
    localparam logic [5:0] FILT_LAST = 6'h28;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h2000;
    localparam logic [15:0] IO_RESET = 16'h0000;
    localparam logic [15:0] BIAS_RESET = 16'h0000;
    localparam logic [15:0] MISC_RESET = 16'h0000;
    localparam logic [15:0] ERREN_RESET = 16'h0020;
    localparam logic [23:0] CHAN0_RESET = 24'h800001;
    localparam logic [23:0] CHAN_RESET = 24'h000001;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [23:0] FILT_RESET = 24'h000030;

    // Fields
    localparam int CTRL_MODE_LSB = 2;
    localparam int MODE_W = 4;
    localparam logic [15:0] CTRL_MODE_MASK = 16'h003c;
    localparam logic [3:0] MODE_CONT = 4'h0;
    localparam logic [3:0] MODE_STANDBY = 4'h2;
    localparam logic [3:0] MODE_POWER_DOWN = 4'h3;
    localparam logic [3:0] MODE_IDLE = 4'h4;
    localparam int CHAN_SWITCH_BIT = 15;
    localparam int CHAN_SETUP_LSB = 20;
    localparam int CFG_GAIN_LSB = 1;
    localparam int CFG_BYPASS_BIT = 4;
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam int MISC_STBY_OUT_BIT = 0;
    localparam logic [1:0] IRQ_ROUTE_P2 = 2'h2;
    localparam logic [15:0] IO_WR_MASK = 16'h07ff;

    // Serial framing
    localparam int CMD_WEN_BIT = 7;
    localparam int CMD_RNW_BIT = 6;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] READ_W = 5'h18;
    localparam logic [6:0] RESET_ONES = 7'h40;

    typedef struct packed {
        logic [4:0] reserved;
        logic sync_clear;
        logic [1:0] irq_pin_route;
        logic [3:0] out_pin_level;
        logic [3:0] out_pin_enable;
    } pmgc_io_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [23:0] wdata;
    } pmgc_req_type;

    typedef enum logic [1:0] {
        PS_CONVERT = 2'b00,
        PS_STANDBY = 2'b01,
        PS_IDLE = 2'b10,
        PS_DOWN = 2'b11
    } pmgc_pstate_type;

    typedef enum logic {
        SP_CMD = 1'b0,
        SP_DATA = 1'b1
    } pmgc_phase_type;

    function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo,
                                      input logic [5:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Frame length in bits; unmapped addresses take one byte
    function automatic logic [4:0] reg_bits(input logic [5:0] a);
        if (a == STATUS_ADDR) reg_bits = 5'h08;
        else if (in_range(a, CHAN_BASE, CHAN_LAST) || in_range(a, FILT_BASE, FILT_LAST))
            reg_bits = 5'h18;
        else if (a == CTRL_ADDR || a == IO_ADDR || a == BIAS_ADDR || a == MISC_ADDR ||
                 a == ERREN_ADDR || in_range(a, CFG_BASE, CFG_LAST))
            reg_bits = 5'h10;
        else reg_bits = 5'h08;
    endfunction : reg_bits

endpackage : pmgc_pkg

// file: pmgc_serial_port.sv
`timescale 1ns/1ps
module pmgc_serial_port (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_din_in,
    input wire logic [23:0] rd_data_in,
    output logic spi_dout_out,
    output pmgc_pkg::pmgc_req_type req_out,
    output logic soft_rst_out
);
    logic [1:0] cs_sync_reg, sclk_sync_reg, din_sync_reg;
    logic sclk_prev_reg;
    pmgc_pkg::pmgc_phase_type phase_reg;
    logic [4:0] cnt_reg, len_reg;
    logic rnw_reg;
    logic [23:0] in_reg, out_reg;
    logic [6:0] ones_reg;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cs_sync_reg <= 2'h3;
            sclk_sync_reg <= 2'h3;
            din_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b1;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_in};
            sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk_in};
            din_sync_reg <= {din_sync_reg[0], spi_din_in};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    // Clock idles high; sample on rise, drive on fall
    wire rise = sclk_sync_reg[1] & ~sclk_prev_reg;
    wire fall = ~sclk_sync_reg[1] & sclk_prev_reg;
    wire din_bit = din_sync_reg[1];
    wire [7:0] cmd_byte = {in_reg[6:0], din_bit};
    wire [4:0] frame_end = (phase_reg == pmgc_pkg::SP_CMD) ? pmgc_pkg::CMD_BITS - 5'h01
                                                           : len_reg - 5'h01;
    wire last_bit = rise && (cnt_reg == frame_end);
    wire ones_hit = rise && din_bit && (ones_reg == pmgc_pkg::RESET_ONES - 7'h01);
    wire abort = cs_sync_reg[1] || ones_hit;

    always_ff @(posedge clk_in) begin
        if (!nrst_in || abort) begin
            phase_reg <= pmgc_pkg::SP_CMD;
            cnt_reg <= 5'h00;
            len_reg <= pmgc_pkg::CMD_BITS;
            rnw_reg <= 1'b0;
            in_reg <= 24'h000000;
            out_reg <= 24'h000000;
            ones_reg <= 7'h00;
            spi_dout_out <= 1'b0;
            req_out <= '0;
        end else begin
            req_out.wr <= 1'b0;
            req_out.rd <= 1'b0;
            if (rise) begin
                in_reg <= {in_reg[22:0], din_bit};
                ones_reg <= din_bit ? ones_reg + 7'h01 : 7'h00;
                cnt_reg <= last_bit ? 5'h00 : cnt_reg + 5'h01;
            end
            if (req_out.rd) begin
                out_reg <= rd_data_in << (pmgc_pkg::READ_W - len_reg);
            end else if (fall && phase_reg == pmgc_pkg::SP_DATA && rnw_reg) begin
                spi_dout_out <= out_reg[23];
                out_reg <= {out_reg[22:0], 1'b0};
            end
            // A command with the write-enable bit high is dropped
            if (last_bit && phase_reg == pmgc_pkg::SP_CMD && !cmd_byte[pmgc_pkg::CMD_WEN_BIT]) begin
                phase_reg <= pmgc_pkg::SP_DATA;
                rnw_reg <= cmd_byte[pmgc_pkg::CMD_RNW_BIT];
                len_reg <= pmgc_pkg::reg_bits(cmd_byte[5:0]);
                req_out.addr <= cmd_byte[5:0];
                req_out.rd <= cmd_byte[pmgc_pkg::CMD_RNW_BIT];
            end
            if (last_bit && phase_reg == pmgc_pkg::SP_DATA) begin
                phase_reg <= pmgc_pkg::SP_CMD;
                req_out.wr <= ~rnw_reg;
                req_out.wdata <= {in_reg[22:0], din_bit};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) soft_rst_out <= 1'b0;
        else soft_rst_out <= ones_hit;
    end
endmodule : pmgc_serial_port

// file: pmgc_power_ctrl.sv
`timescale 1ns/1ps
module pmgc_power_ctrl (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_din_in,
    input wire logic data_ready_in,
    input wire logic [3:0] seq_channel_in,
    output logic spi_dout_out,
    output logic [3:0] out_pin_level_out,
    output logic [3:0] out_pin_oe_out,
    output logic bridge_switch_out,
    output logic [2:0] gain_code_out,
    output logic [15:0] bias_pin_select_out,
    output logic modulator_reset_out,
    output logic standby_out,
    output logic powered_down_out,
    output logic conv_pending_n_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Serial port
    pmgc_pkg::pmgc_req_type req;
    logic soft_rst;
    logic [23:0] rd_data;

    pmgc_serial_port u_port (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .spi_cs_n_in(spi_cs_n_in),
        .spi_sclk_in(spi_sclk_in),
        .spi_din_in(spi_din_in),
        .rd_data_in(rd_data),
        .spi_dout_out(spi_dout_out),
        .req_out(req),
        .soft_rst_out(soft_rst)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] ctrl_reg, bias_reg, misc_reg, erren_reg;
    pmgc_pkg::pmgc_io_type io_reg;
    logic [23:0] chan_reg [pmgc_pkg::N_CHAN];
    logic [15:0] cfg_reg [pmgc_pkg::N_SETUP];
    logic [23:0] filt_reg [pmgc_pkg::N_SETUP];
    logic por_flag_reg;
    pmgc_pkg::pmgc_pstate_type pstate_reg, pstate_next;

    // Only the digital-supply reset and the serial reset reach here; there is
    // no analog supply monitor input, so analog dips cannot reset anything
    wire rst_all = !nrst_in || soft_rst;
    wire is_down = pstate_reg == pmgc_pkg::PS_DOWN;
    // Registers lose their contents while powered down
    wire reg_clear = rst_all || is_down;

    function automatic pmgc_pkg::pmgc_pstate_type mode_state(input logic [3:0] m);
        case (m)
            pmgc_pkg::MODE_STANDBY: mode_state = pmgc_pkg::PS_STANDBY;
            pmgc_pkg::MODE_IDLE: mode_state = pmgc_pkg::PS_IDLE;
            pmgc_pkg::MODE_POWER_DOWN: mode_state = pmgc_pkg::PS_DOWN;
            default: mode_state = pmgc_pkg::PS_CONVERT;
        endcase
    endfunction : mode_state

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr_ok = req.wr && !is_down;
    wire ctrl_wr = wr_ok && req.addr == pmgc_pkg::CTRL_ADDR;
    wire io_wr = wr_ok && req.addr == pmgc_pkg::IO_ADDR;
    wire bias_wr = wr_ok && req.addr == pmgc_pkg::BIAS_ADDR;
    wire misc_wr = wr_ok && req.addr == pmgc_pkg::MISC_ADDR;
    wire erren_wr = wr_ok && req.addr == pmgc_pkg::ERREN_ADDR;
    wire chan_wr = wr_ok && pmgc_pkg::in_range(req.addr, pmgc_pkg::CHAN_BASE, pmgc_pkg::CHAN_LAST);
    wire cfg_wr = wr_ok && pmgc_pkg::in_range(req.addr, pmgc_pkg::CFG_BASE, pmgc_pkg::CFG_LAST);
    wire filt_wr = wr_ok && pmgc_pkg::in_range(req.addr, pmgc_pkg::FILT_BASE, pmgc_pkg::FILT_LAST);
    wire [5:0] chan_off = req.addr - pmgc_pkg::CHAN_BASE;
    wire [5:0] cfg_off = req.addr - pmgc_pkg::CFG_BASE;
    wire [5:0] filt_off = req.addr - pmgc_pkg::FILT_BASE;
    wire status_rd = req.rd && req.addr == pmgc_pkg::STATUS_ADDR;

    wire [3:0] mode_wr = req.wdata[pmgc_pkg::CTRL_MODE_LSB +: pmgc_pkg::MODE_W];
    wire pd_req = mode_wr == pmgc_pkg::MODE_POWER_DOWN;
    wire pd_ok = pd_req && pstate_reg == pmgc_pkg::PS_STANDBY;
    // A power-down request from anywhere but standby falls back to continuous
    wire [15:0] ctrl_wdata = (pd_req && !pd_ok) ? (req.wdata[15:0] & ~pmgc_pkg::CTRL_MODE_MASK)
                                                : req.wdata[15:0];
    // Any mode write moves idle or standby on; power-down waits for reset
    assign pstate_next = ctrl_wr ? mode_state(ctrl_wdata[pmgc_pkg::CTRL_MODE_LSB +:
                                   pmgc_pkg::MODE_W]) : pstate_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_in) begin
        if (rst_all) pstate_reg <= pmgc_pkg::PS_CONVERT;
        else pstate_reg <= pstate_next;
    end

    always_ff @(posedge clk_in) begin
        if (reg_clear) begin
            ctrl_reg <= pmgc_pkg::CTRL_RESET;
            io_reg <= pmgc_pkg::IO_RESET;
            bias_reg <= pmgc_pkg::BIAS_RESET;
            misc_reg <= pmgc_pkg::MISC_RESET;
            erren_reg <= pmgc_pkg::ERREN_RESET;
        end else begin
            if (ctrl_wr) ctrl_reg <= ctrl_wdata;
            if (io_wr) io_reg <= req.wdata[15:0] & pmgc_pkg::IO_WR_MASK;
            if (bias_wr) bias_reg <= req.wdata[15:0];
            if (misc_wr) misc_reg <= req.wdata[15:0];
            if (erren_wr) erren_reg <= req.wdata[15:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < pmgc_pkg::N_CHAN; g++) begin : gen_chan
            always_ff @(posedge clk_in) begin
                if (reg_clear) chan_reg[g] <= (g == 0) ? pmgc_pkg::CHAN0_RESET
                                                      : pmgc_pkg::CHAN_RESET;
                else if (chan_wr && chan_off[3:0] == g) chan_reg[g] <= req.wdata;
            end
        end
        for (g = 0; g < pmgc_pkg::N_SETUP; g++) begin : gen_setup
            always_ff @(posedge clk_in) begin
                if (reg_clear) begin
                    cfg_reg[g] <= pmgc_pkg::CFG_RESET;
                    filt_reg[g] <= pmgc_pkg::FILT_RESET;
                end else begin
                    if (cfg_wr && cfg_off[2:0] == g) cfg_reg[g] <= req.wdata[15:0];
                    if (filt_wr && filt_off[2:0] == g) filt_reg[g] <= req.wdata;
                end
            end
        end
    endgenerate

    // Reset raises the flag; only a status read lowers it
    always_ff @(posedge clk_in) begin
        if (rst_all) por_flag_reg <= 1'b1;
        else if (status_rd) por_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [7:0] status_word = {conv_pending_n_out, por_flag_reg, 6'h00};
    assign rd_data =
        (req.addr == pmgc_pkg::STATUS_ADDR) ? {16'h0000, status_word} :
        (req.addr == pmgc_pkg::CTRL_ADDR) ? {8'h00, ctrl_reg} :
        (req.addr == pmgc_pkg::IO_ADDR) ? {8'h00, io_reg} :
        (req.addr == pmgc_pkg::BIAS_ADDR) ? {8'h00, bias_reg} :
        (req.addr == pmgc_pkg::MISC_ADDR) ? {8'h00, misc_reg} :
        (req.addr == pmgc_pkg::ERREN_ADDR) ? {8'h00, erren_reg} :
        pmgc_pkg::in_range(req.addr, pmgc_pkg::CHAN_BASE, pmgc_pkg::CHAN_LAST) ?
            chan_reg[chan_off[3:0]] :
        pmgc_pkg::in_range(req.addr, pmgc_pkg::CFG_BASE, pmgc_pkg::CFG_LAST) ?
            {8'h00, cfg_reg[cfg_off[2:0]]} :
        pmgc_pkg::in_range(req.addr, pmgc_pkg::FILT_BASE, pmgc_pkg::FILT_LAST) ?
            filt_reg[filt_off[2:0]] : 24'h000000;

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    wire converting = pstate_reg == pmgc_pkg::PS_CONVERT;
    wire in_standby = pstate_reg == pmgc_pkg::PS_STANDBY;
    wire [23:0] act_chan = chan_reg[seq_channel_in];
    wire [2:0] act_setup = act_chan[pmgc_pkg::CHAN_SETUP_LSB +: 3];
    wire [15:0] act_cfg = cfg_reg[act_setup];
    wire [2:0] gain_next = act_cfg[pmgc_pkg::CFG_BYPASS_BIT] ? pmgc_pkg::GAIN_UNITY
                                                             : act_cfg[pmgc_pkg::CFG_GAIN_LSB +: 3];
    wire switch_next = converting && act_chan[pmgc_pkg::CHAN_SWITCH_BIT];
    // Held high outside conversion, else low while a result waits
    wire pend_next = !converting || !data_ready_in;

    wire irq_sel = io_reg.irq_pin_route == pmgc_pkg::IRQ_ROUTE_P2;
    wire stby_sel = misc_reg[pmgc_pkg::MISC_STBY_OUT_BIT];
    wire [3:0] alt_sel = {stby_sel, 1'b0, irq_sel, 1'b0};
    wire [3:0] alt_lvl = {in_standby, 1'b0, conv_pending_n_out, 1'b0};
    wire [3:0] oe_next, lvl_next;
    generate
        for (g = 0; g < 4; g++) begin : gen_pin
            assign oe_next[g] = !is_down && (alt_sel[g] || io_reg.out_pin_enable[g]);
            assign lvl_next[g] = alt_sel[g] ? alt_lvl[g] : io_reg.out_pin_level[g];
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            out_pin_oe_out <= 4'h0;
            out_pin_level_out <= 4'h0;
            bridge_switch_out <= 1'b0;
            gain_code_out <= pmgc_pkg::GAIN_UNITY;
            bias_pin_select_out <= pmgc_pkg::BIAS_RESET;
            modulator_reset_out <= 1'b1;
            standby_out <= 1'b0;
            powered_down_out <= 1'b0;
            conv_pending_n_out <= 1'b1;
        end else begin
            out_pin_oe_out <= oe_next;
            out_pin_level_out <= lvl_next;
            bridge_switch_out <= switch_next;
            gain_code_out <= gain_next;
            bias_pin_select_out <= bias_reg;
            modulator_reset_out <= !converting;
            standby_out <= in_standby;
            powered_down_out <= is_down;
            conv_pending_n_out <= pend_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    pin_drive_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        !io_reg.out_pin_enable[0] |=> !out_pin_oe_out[0])
        else $error("pin 1 driven while disabled");

    pin_level_follow_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (io_reg.out_pin_enable[2] && !is_down) |=>
            (out_pin_oe_out[2] && out_pin_level_out[2] == $past(io_reg.out_pin_level[2])))
        else $error("pin 3 level does not follow its bit");

    irq_pin_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (irq_sel && !is_down) |=> (out_pin_oe_out[1] &&
            out_pin_level_out[1] == $past(conv_pending_n_out)))
        else $error("pin 2 not carrying data ready");

    standby_pin_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (stby_sel && in_standby) |=> (out_pin_oe_out[3] && out_pin_level_out[3]))
        else $error("pin 4 not flagging standby");

    bridge_switch_follow_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        converting |=> bridge_switch_out == $past(act_chan[pmgc_pkg::CHAN_SWITCH_BIT]))
        else $error("bridge switch disagrees with channel bit");

    gain_bypass_unity_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        act_cfg[pmgc_pkg::CFG_BYPASS_BIT] |=> gain_code_out == pmgc_pkg::GAIN_UNITY)
        else $error("bypassed setup not at unity gain");

    por_flag_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        status_rd |=> !por_flag_reg ##1 (por_flag_reg == $past(por_flag_reg)))
        else $error("power-on flag not cleared by status read");

    pd_only_standby_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (ctrl_wr && pd_req && pstate_reg != pmgc_pkg::PS_STANDBY) |=>
            (pstate_reg == pmgc_pkg::PS_CONVERT && !powered_down_out) ##1 !modulator_reset_out)
        else $error("power-down entered without standby");

    pd_holds_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        is_down |=> (is_down && ctrl_reg == pmgc_pkg::CTRL_RESET) ##1 (out_pin_oe_out == 4'h0))
        else $error("power-down left or registers kept");

    idle_mod_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (pstate_reg == pmgc_pkg::PS_IDLE) |=> modulator_reset_out)
        else $error("modulator running in idle");

    standby_pending_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        (in_standby && !ctrl_wr) [*2] |=> conv_pending_n_out)
        else $error("conv_pending_n low in standby");

    io_reserved_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in || soft_rst)
        io_wr |=> io_reg.reserved == 5'h00)
        else $error("reserved io bits stored");

endmodule : pmgc_power_ctrl

// file: pmgc_host_model.sv
`timescale 1ns/1ps
module pmgc_host_model (
    input wire logic clk_in,
    input wire logic dout_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out,
    output logic [23:0] rd_word_out,
    output logic rd_done_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
        rd_word_out = 24'h000000;
        rd_done_out = 1'b0;
    end
    // Five clocks low and six high keep sclk near 3.6 MHz, under the 5 MHz ceiling
    task automatic xfer(input logic [63:0] bits, input int n, input logic rd);
        @(negedge clk_in) cs_n_out = 1'b0;
        // Short reads must not carry bits of the previous frame
        rd_word_out = 24'h000000;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk_in) sclk_out = 1'b0;
            din_out = bits[i];
            repeat (5) @(negedge clk_in);
            sclk_out = 1'b1;
            if (i < n - 8)
                rd_word_out = {rd_word_out[22:0], dout_in};
            repeat (5) @(negedge clk_in);
        end
        cs_n_out = 1'b1;
        // Released line must not keep showing the last bit
        din_out = ~din_out;
        rd_done_out = rd;
        @(negedge clk_in) rd_done_out = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask : xfer
endmodule : pmgc_host_model

// file: power_mode_and_gpo_control_bench.sv
`timescale 1ns/1ps
module power_mode_and_gpo_control_bench;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic data_ready_in = 1'b0;
    logic [3:0] seq_channel_in = 4'h0;
    logic cs_n, sclk, din, dout, rd_done, bridge, stby, down, pend_n, mod_rst;
    logic [23:0] rd_word;
    logic [3:0] lvl, oe;
    logic [2:0] gain;
    logic [15:0] bias;
    logic [23:0] exp_q[$];
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] r;
    always #12.5 clk_in = ~clk_in;
    pmgc_host_model i_pmgc_host_model (.clk_in(clk_in), .dout_in(dout), .cs_n_out(cs_n),
        .sclk_out(sclk), .din_out(din), .rd_word_out(rd_word), .rd_done_out(rd_done));
    pmgc_power_ctrl i_pmgc_power_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .spi_cs_n_in(cs_n),
        .spi_sclk_in(sclk), .spi_din_in(din), .data_ready_in(data_ready_in),
        .seq_channel_in(seq_channel_in), .spi_dout_out(dout), .out_pin_level_out(lvl),
        .out_pin_oe_out(oe), .bridge_switch_out(bridge), .gain_code_out(gain),
        .bias_pin_select_out(bias), .modulator_reset_out(mod_rst), .standby_out(stby),
        .powered_down_out(down), .conv_pending_n_out(pend_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [23:0] d, input int n);
        i_pmgc_host_model.xfer((64'(a) << n) | (64'(d) & ((64'h1 << n) - 1)), n + 8, 1'b0);
    endtask : wr
    task automatic rd(input logic [5:0] a, input int n, input logic [23:0] e);
        exp_q.push_back(e);
        i_pmgc_host_model.xfer(64'({2'b01, a}) << n, n + 8, 1'b1);
    endtask : rd
    task automatic final_report;
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // Oldest note is matched against each completed read
    always @(posedge clk_in) begin
        if (rd_done === 1'b1 && exp_q.size() > 0)
            check("read word", rd_word, exp_q.pop_front());
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h0d29);
        repeat (16) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rd(pmgc_pkg::STATUS_ADDR, 8, 24'h0000c0);
        rd(pmgc_pkg::STATUS_ADDR, 8, 24'h000080);
        rd(pmgc_pkg::CTRL_ADDR, 16, 24'(pmgc_pkg::CTRL_RESET));
        rd(pmgc_pkg::IO_ADDR, 16, 24'(pmgc_pkg::IO_RESET));
        rd(pmgc_pkg::ERREN_ADDR, 16, 24'(pmgc_pkg::ERREN_RESET));
        rd(pmgc_pkg::CHAN_BASE, 24, pmgc_pkg::CHAN0_RESET);
        rd(pmgc_pkg::CFG_BASE, 16, 24'(pmgc_pkg::CFG_RESET));
        rd(pmgc_pkg::FILT_BASE, 24, pmgc_pkg::FILT_RESET);
        for (int i = 0; i < 4; i++) begin
            r = $urandom() & 32'hfffffcff;
            wr(pmgc_pkg::IO_ADDR, r[23:0], 16);
            check("pin enable", 24'(oe), 24'(r[3:0]));
            check("pin level", 24'(lvl & oe), 24'(r[7:4] & r[3:0]));
            rd(pmgc_pkg::IO_ADDR, 16, 24'(r[15:0] & pmgc_pkg::IO_WR_MASK));
        end
        wr(pmgc_pkg::IO_ADDR, 24'h000202, 16);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_in) data_ready_in = k[0];
            repeat (4) @(negedge clk_in);
            check("pin2 ready", 24'(lvl[1]), {23'h000000, ~k[0]});
        end
        data_ready_in = 1'b0;
        // Commands with the top bit high are dropped; io read below must be unchanged
        i_pmgc_host_model.xfer(64'h83ffff, 24, 1'b0);
        wr(pmgc_pkg::MISC_ADDR, 24'h000001, 16);
        wr(pmgc_pkg::CTRL_ADDR, 24'(pmgc_pkg::CTRL_RESET | 16'h0008), 16);
        check("standby", 24'({stby, pend_n, lvl[3]}), 24'h7);
        rd(pmgc_pkg::IO_ADDR, 16, 24'h000202);
        wr(pmgc_pkg::CTRL_ADDR, 24'(pmgc_pkg::CTRL_RESET | 16'h0010), 16);
        check("idle", 24'({mod_rst, stby}), 24'h2);
        rd(pmgc_pkg::IO_ADDR, 16, 24'h000202);
        wr(pmgc_pkg::CTRL_ADDR, 24'(pmgc_pkg::CTRL_RESET | 16'h000c), 16);
        check("down from idle", 24'(down), 24'h0);
        rd(pmgc_pkg::CTRL_ADDR, 16, 24'(pmgc_pkg::CTRL_RESET));
        wr(pmgc_pkg::CTRL_ADDR, 24'(pmgc_pkg::CTRL_RESET | 16'h0008), 16);
        wr(pmgc_pkg::CTRL_ADDR, 24'(pmgc_pkg::CTRL_RESET | 16'h000c), 16);
        check("down", 24'(down), 24'h1);
        rd(pmgc_pkg::IO_ADDR, 16, 24'h000000);
        i_pmgc_host_model.xfer({64{1'b1}}, 64, 1'b0);
        check("down after reset", 24'(down), 24'h0);
        rd(pmgc_pkg::STATUS_ADDR, 8, 24'h0000c0);
        rd(pmgc_pkg::MISC_ADDR, 16, 24'(pmgc_pkg::MISC_RESET));
        wr(pmgc_pkg::CFG_BASE, 24'h00000e, 16);
        check("gain", 24'(gain), 24'h000007);
        wr(pmgc_pkg::CFG_BASE, 24'h00001e, 16);
        check("bypass gain", 24'(gain), 24'h000000);
        r = $urandom();
        wr(pmgc_pkg::BIAS_ADDR, r[23:0], 16);
        check("bias", 24'(bias), 24'(r[15:0]));
        wr(pmgc_pkg::CHAN_BASE, pmgc_pkg::CHAN0_RESET | 24'h008000, 24);
        check("switch ch0", 24'(bridge), 24'h1);
        @(negedge clk_in) seq_channel_in = 4'h1;
        repeat (4) @(negedge clk_in);
        check("switch ch1", 24'(bridge), 24'h0);
        repeat (4) @(negedge clk_in);
        final_report();
    end
endmodule : power_mode_and_gpo_control_bench
